/* File: include/icmc_pkg.sv */
// Constants, field layouts and decode functions of the indexed clock/mode block
`default_nettype none
package icmc_pkg;
  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_INDEX = 3'h3;
  localparam logic [2:0] ADDR_WINDOW = 3'h7;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // ---------------------------------------------------------------
  // Pointer fields
  // ---------------------------------------------------------------
  localparam int PTR_TEST = 7;
  localparam int PTR_S1_HI = 6;
  localparam int PTR_S1_LO = 5;
  localparam int PTR_S0_HI = 4;
  localparam int PTR_S0_LO = 3;
  localparam int PTR_IDX_HI = 2;
  // ---------------------------------------------------------------
  // Indexed registers
  // ---------------------------------------------------------------
  localparam int NUM_REGS = 6;
  localparam logic [2:0] IDX_CLKSEL = 3'h0;
  localparam logic [2:0] IDX_GATING = 3'h1;
  localparam logic [2:0] IDX_S0IRQ = 3'h2;
  localparam logic [2:0] IDX_S1IRQ = 3'h3;
  localparam logic [2:0] IDX_PPIRQ = 3'h4;
  localparam logic [2:0] IDX_MODE = 3'h5;
  localparam logic [7:0] MASK_CLKSEL = 8'h07;
  localparam logic [7:0] MASK_GATING = 8'hCE;
  localparam logic [7:0] MASK_LOW4 = 8'h0F;
  localparam int ROUTE_HI = 3;
  localparam int GATE_S1 = 7;
  localparam int GATE_S0 = 6;
  localparam int GATE_BUS = 3;
  localparam int GATE_KBD = 2;
  localparam int GATE_OSC = 1;
  localparam int MODE_PD = 3;
  localparam int MODE_IRQ = 2;
  localparam int MODE_BUS = 1;
  localparam int MODE_FIFO = 0;
  // ---------------------------------------------------------------
  // Coprocessor clock codes and timing
  // ---------------------------------------------------------------
  localparam logic [2:0] CC_8M_33 = 3'h0;
  localparam logic [2:0] CC_9M6_33 = 3'h1;
  localparam logic [2:0] CC_12M_33 = 3'h2;
  localparam logic [2:0] CC_12M_50 = 3'h3;
  localparam logic [2:0] CC_16M_33 = 3'h4;
  localparam logic [2:0] CC_16M_50 = 3'h5;
  localparam logic [2:0] CC_LOW = 3'h6;
  localparam logic [2:0] CC_HIGH = 3'h7;
  localparam int SYS_KHZ = 50000;
  localparam int F_8M_KHZ = 8000;
  localparam int F_9M6_KHZ = 9600;
  localparam int F_12M_KHZ = 12000;
  localparam int F_16M_KHZ = 16000;
  localparam int OSC_START_MS = 30;
  localparam int OSC_START_CYC = OSC_START_MS * SYS_KHZ;
  localparam int CLK_W = 8;
  // Writable bits of each indexed register; reserved bits stay zero
  function automatic logic [7:0] reg_mask(input logic [2:0] idx);
    case (idx)
      IDX_CLKSEL: reg_mask = MASK_CLKSEL;
      IDX_GATING: reg_mask = MASK_GATING;
      IDX_S0IRQ, IDX_S1IRQ, IDX_PPIRQ, IDX_MODE: reg_mask = MASK_LOW4;
      default: reg_mask = READ_ZERO;
    endcase
  endfunction
  // Coprocessor clock period in system cycles; the period rounds down, so the rate rounds up
  function automatic logic [CLK_W-1:0] cc_period(input logic [2:0] code);
    case (code)
      CC_8M_33: cc_period = CLK_W'(SYS_KHZ / F_8M_KHZ);
      CC_9M6_33: cc_period = CLK_W'(SYS_KHZ / F_9M6_KHZ);
      CC_12M_33, CC_12M_50: cc_period = CLK_W'(SYS_KHZ / F_12M_KHZ);
      default: cc_period = CLK_W'(SYS_KHZ / F_16M_KHZ);
    endcase
  endfunction
  // High time: one third or one half of the period
  function automatic logic [CLK_W-1:0] cc_high(input logic [2:0] code);
    logic [CLK_W-1:0] p;
    p = cc_period(code);
    if (code == CC_12M_50 || code == CC_16M_50) begin
      cc_high = p >> 1;
    end else begin
      cc_high = p / CLK_W'(3);
    end
  endfunction
endpackage
`default_nettype wire

/* File: verilog/icmc_sync.sv */
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module icmc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_level;
  // A bit changes only once stages two and three agree
  assign next_level = (s2 & s3) | (level & (s2 ^ s3));
  // ---------------------------------------------------------------
  // Stages
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
      level <= RESET_VAL;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/icmc_clkgen.sv */
// Programmable clock divider with freeze, force-low and force-high
`default_nettype none
module icmc_clkgen #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] period,
  input wire logic [W-1:0] high,
  input wire logic freeze,
  input wire logic force_low,
  input wire logic force_high,
  output logic clk_out
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_out;
  // Wrap at period-1; a new period takes effect at once, glitch allowed
  assign next_cnt = (cnt + W'(1) >= period) ? '0 : cnt + W'(1);
  assign next_out = force_low ? 1'b0 : force_high ? 1'b1 : freeze ? clk_out : (next_cnt < high);
  // ---------------------------------------------------------------
  // Counter and output
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      clk_out <= 1'b0;
    end else begin
      cnt <= (force_low || force_high || freeze) ? cnt : next_cnt;
      clk_out <= next_out;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/icmc_top.sv */
// Indexed clock, sleep and port-mode configuration block
`default_nettype none
module icmc_top #(
  parameter int OSC_START_CYCLES = icmc_pkg::OSC_START_CYC,
  parameter logic [7:0] KBD_PERIOD = 8'h10,
  parameter logic [7:0] BUS_PERIOD = 8'h04
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic parallel_port_select_n,
  input wire logic serial0_select_n,
  input wire logic serial1_select_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  input wire logic printer_selected_in,
  input wire logic printer_busy_in,
  input wire logic printer_paper_end_in,
  input wire logic serial0_irq,
  input wire logic serial1_irq,
  input wire logic parallel_irq,
  input wire logic [1:0] serial_fifo_enable,
  input wire logic parallel_dir_bit,
  output logic mux_serial0_irq,
  output logic mux_serial1_irq,
  output logic mux_parallel_irq,
  output logic [1:0] serial0_clock_source,
  output logic [1:0] serial1_clock_source,
  output logic serial0_clock_gate,
  output logic serial1_clock_gate,
  output logic coproc_clock_out,
  output logic keyboard_clock_out,
  output logic bus_clock_out,
  output logic oscillator_stop,
  output logic sleep_mode,
  output logic port_power_down,
  output logic parallel_irq_style,
  output logic parallel_bus_style,
  output logic serial_fifo_allow,
  output logic [1:0] serial_fifo_active,
  output logic parallel_status_int,
  output logic parallel_dir_effective,
  output logic [3:0] serial0_irq_route,
  output logic [3:0] serial1_irq_route,
  output logic [3:0] parallel_irq_route
);
  localparam int SW = 19;
  localparam logic [SW-1:0] SYNC_RST = {5'h1F, 14'h0000};
  localparam int OW = $clog2(OSC_START_CYCLES + 1);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [SW-1:0] pins_s;
  logic pp_sel_n_s;
  logic s0_sel_n_s;
  logic s1_sel_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic [2:0] addr_s;
  logic [7:0] data_s;
  logic printer_selected_in_s;
  logic busy_s;
  logic pe_s;

  icmc_sync #(.W(SW), .RESET_VAL(SYNC_RST)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin({parallel_port_select_n, serial0_select_n, serial1_select_n,
          io_read_strobe_n, io_write_strobe_n, host_addr, host_data_in,
          printer_selected_in, printer_busy_in, printer_paper_end_in}),
    .level(pins_s)
  );

  // Unpack the synchronised bundle
  assign {pp_sel_n_s, s0_sel_n_s, s1_sel_n_s, rd_n_s, wr_n_s} = pins_s[18:14];
  assign addr_s = pins_s[13:11];
  assign data_s = pins_s[10:3];
  assign {printer_selected_in_s, busy_s, pe_s} = pins_s[2:0];

  // ---------------------------------------------------------------
  // Sleep detect and bus decode
  // ---------------------------------------------------------------
  logic wr_n_d;
  logic sleep_now;
  logic bus_sel;
  logic wr_pulse;
  logic ptr_wr;
  logic win_wr;
  logic rd_index;
  logic rd_window;
  logic rd_active;

  // All three selects low together means sleep, never a bus cycle
  assign sleep_now = ~pp_sel_n_s & ~s0_sel_n_s & ~s1_sel_n_s;
  // Bus frozen while asleep so a stray strobe cannot alter state
  assign bus_sel = ~pp_sel_n_s & ~sleep_now;
  // Write acts once, on the strobe's synchronised falling edge
  assign wr_pulse = bus_sel & ~wr_n_s & wr_n_d & rd_n_s;
  assign ptr_wr = wr_pulse & (addr_s == icmc_pkg::ADDR_INDEX);
  assign win_wr = wr_pulse & (addr_s == icmc_pkg::ADDR_WINDOW);
  assign rd_index = bus_sel & ~rd_n_s & wr_n_s & (addr_s == icmc_pkg::ADDR_INDEX);
  assign rd_window = bus_sel & ~rd_n_s & wr_n_s & (addr_s == icmc_pkg::ADDR_WINDOW);
  assign rd_active = rd_index | rd_window;

  // ---------------------------------------------------------------
  // Index pointer
  // ---------------------------------------------------------------
  logic [7:0] pointer;
  logic [2:0] window_index;

  // Loads only on its own write; any other cycle leaves it alone
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pointer <= icmc_pkg::PTR_RESET;
      wr_n_d <= 1'b1;
    end else begin
      pointer <= ptr_wr ? data_s : pointer;
      wr_n_d <= wr_n_s;
    end
  end

  assign window_index = pointer[icmc_pkg::PTR_IDX_HI:0];

  // ---------------------------------------------------------------
  // Indexed registers
  // ---------------------------------------------------------------
  logic [7:0] regs [icmc_pkg::NUM_REGS];
  logic [7:0] window_data;
  logic index_mapped;

  // Reserved bits are masked off, so they always read zero
  for (genvar i = 0; i < icmc_pkg::NUM_REGS; i++) begin : g_reg
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        regs[i] <= icmc_pkg::REG_RESET;
      end else if (win_wr && window_index == 3'(i)) begin
        regs[i] <= data_s & icmc_pkg::reg_mask(3'(i));
      end
    end
  end

  // Codes 110 and 111 are unmapped: writes dropped, reads zero
  assign index_mapped = window_index < 3'(icmc_pkg::NUM_REGS);
  assign window_data = index_mapped ? regs[window_index] : icmc_pkg::READ_ZERO;

  logic [7:0] clksel;
  logic [7:0] gating;
  logic [7:0] mode;
  assign clksel = regs[icmc_pkg::IDX_CLKSEL];
  assign gating = regs[icmc_pkg::IDX_GATING];
  assign mode = regs[icmc_pkg::IDX_MODE];

  // ---------------------------------------------------------------
  // Host read data
  // ---------------------------------------------------------------
  logic [7:0] next_rdata;
  assign next_rdata = rd_index ? pointer : rd_window ? window_data : host_data_out;

  // Bus is released whenever the read ends or sleep begins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      host_data_out <= icmc_pkg::READ_ZERO;
      host_data_oe <= 1'b0;
    end else begin
      host_data_out <= next_rdata;
      host_data_oe <= rd_active;
    end
  end

  // ---------------------------------------------------------------
  // Oscillator stop and start-up wait
  // ---------------------------------------------------------------
  logic osc_stop_req;
  logic osc_ok;
  logic [OW-1:0] osc_cnt;
  logic osc_done;

  assign osc_stop_req = gating[icmc_pkg::GATE_OSC] | sleep_now;
  assign osc_done = osc_cnt >= OW'(OSC_START_CYCLES - 1);

  // Clocks stay frozen until the oscillator has had time to settle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_cnt <= '0;
      osc_ok <= 1'b0;
      oscillator_stop <= 1'b0;
    end else begin
      osc_cnt <= osc_stop_req ? '0 : osc_done ? osc_cnt : osc_cnt + OW'(1);
      osc_ok <= ~osc_stop_req & osc_done;
      oscillator_stop <= osc_stop_req;
    end
  end

  // ---------------------------------------------------------------
  // Derived clocks
  // ---------------------------------------------------------------
  logic cc_low;
  logic cc_high_force;
  logic [2:0] cc_code;

  assign cc_code = clksel[2:0];
  assign cc_low = sleep_now | (cc_code == icmc_pkg::CC_LOW);
  assign cc_high_force = cc_code == icmc_pkg::CC_HIGH;

  icmc_clkgen #(.W(icmc_pkg::CLK_W)) u_coproc (
    .sys_clk(sys_clk),
    .rst(rst),
    .period(icmc_pkg::cc_period(cc_code)),
    .high(icmc_pkg::cc_high(cc_code)),
    .freeze(~osc_ok),
    .force_low(cc_low),
    .force_high(cc_high_force),
    .clk_out(coproc_clock_out)
  );

  // Keyboard clock: forced low by its gate bit or by sleep
  icmc_clkgen #(.W(icmc_pkg::CLK_W)) u_kbd (
    .sys_clk(sys_clk),
    .rst(rst),
    .period(KBD_PERIOD),
    .high(KBD_PERIOD >> 1),
    .freeze(~osc_ok),
    .force_low(gating[icmc_pkg::GATE_KBD] | sleep_now),
    .force_high(1'b0),
    .clk_out(keyboard_clock_out)
  );

  icmc_clkgen #(.W(icmc_pkg::CLK_W)) u_bus (
    .sys_clk(sys_clk),
    .rst(rst),
    .period(BUS_PERIOD),
    .high(BUS_PERIOD >> 1),
    .freeze(~osc_ok),
    .force_low(gating[icmc_pkg::GATE_BUS] | sleep_now),
    .force_high(1'b0),
    .clk_out(bus_clock_out)
  );

  // ---------------------------------------------------------------
  // Mode, routing and interrupt mux outputs
  // ---------------------------------------------------------------
  logic test_on;
  assign test_on = pointer[icmc_pkg::PTR_TEST];

  // All registered so every output is glitch free at the pins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mux_serial1_irq <= 1'b0;
      mux_serial0_irq <= 1'b0;
      mux_parallel_irq <= 1'b0;
      serial1_clock_source <= 2'h0;
      serial0_clock_source <= 2'h0;
      serial1_clock_gate <= 1'b0;
      serial0_clock_gate <= 1'b0;
      sleep_mode <= 1'b0;
      port_power_down <= 1'b0;
      parallel_irq_style <= 1'b0;
      parallel_bus_style <= 1'b0;
      serial_fifo_allow <= 1'b0;
      serial_fifo_active <= 2'h0;
      parallel_status_int <= 1'b1;
      parallel_dir_effective <= 1'b0;
      serial0_irq_route <= 4'h0;
      serial1_irq_route <= 4'h0;
      parallel_irq_route <= 4'h0;
    end else begin
      mux_serial1_irq <= test_on ? printer_selected_in_s : serial1_irq;
      mux_serial0_irq <= test_on ? busy_s : serial0_irq;
      mux_parallel_irq <= test_on ? pe_s : parallel_irq;
      serial1_clock_source <= pointer[icmc_pkg::PTR_S1_HI:icmc_pkg::PTR_S1_LO];
      serial0_clock_source <= pointer[icmc_pkg::PTR_S0_HI:icmc_pkg::PTR_S0_LO];
      serial1_clock_gate <= gating[icmc_pkg::GATE_S1] | ~osc_ok;
      serial0_clock_gate <= gating[icmc_pkg::GATE_S0] | ~osc_ok;
      sleep_mode <= sleep_now;
      port_power_down <= mode[icmc_pkg::MODE_PD];
      parallel_irq_style <= mode[icmc_pkg::MODE_IRQ];
      parallel_bus_style <= mode[icmc_pkg::MODE_BUS];
      serial_fifo_allow <= mode[icmc_pkg::MODE_FIFO];
      serial_fifo_active <= {2{mode[icmc_pkg::MODE_FIFO]}} & serial_fifo_enable;
      parallel_status_int <= ~mode[icmc_pkg::MODE_IRQ] | parallel_irq;
      parallel_dir_effective <= mode[icmc_pkg::MODE_BUS] & parallel_dir_bit;
      serial0_irq_route <= regs[icmc_pkg::IDX_S0IRQ][icmc_pkg::ROUTE_HI:0];
      serial1_irq_route <= regs[icmc_pkg::IDX_S1IRQ][icmc_pkg::ROUTE_HI:0];
      parallel_irq_route <= regs[icmc_pkg::IDX_PPIRQ][icmc_pkg::ROUTE_HI:0];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_sleep_entry;
    @(posedge sys_clk) disable iff (rst) sleep_now |=> sleep_mode ##1 !host_data_oe;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

  property p_sleep_exit;
    @(posedge sys_clk) disable iff (rst) $fell(sleep_now) |=> !sleep_mode;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) else $error("sleep not left");

  property p_ptr_load;
    @(posedge sys_clk) disable iff (rst) ptr_wr |=> pointer == $past(data_s);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

  property p_ptr_hold;
    @(posedge sys_clk) disable iff (rst) !ptr_wr |=> $stable(pointer);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer changed");

  property p_gate_write;
    @(posedge sys_clk) disable iff (rst) win_wr && window_index == icmc_pkg::IDX_GATING
      |=> gating == ($past(data_s) & icmc_pkg::MASK_GATING);
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("window write lost");

  property p_ptr_read;
    @(posedge sys_clk) disable iff (rst) rd_index && !ptr_wr
      |=> host_data_oe && host_data_out == $past(pointer);
  endproperty
  a_ptr_read: assert property (p_ptr_read) else $error("pointer read wrong");

  property p_test_mux;
    @(posedge sys_clk) disable iff (rst) test_on |=> mux_serial1_irq == $past(printer_selected_in_s)
      && mux_parallel_irq == $past(pe_s);
  endproperty
  a_test_mux: assert property (p_test_mux) else $error("test mux wrong");

  property p_kbd_low;
    @(posedge sys_clk) disable iff (rst) (gating[icmc_pkg::GATE_KBD] || sleep_now) [*2]
      |-> !keyboard_clock_out;
  endproperty
  a_kbd_low: assert property (p_kbd_low) else $error("keyboard clock not low");

  property p_sleep_low;
    @(posedge sys_clk) disable iff (rst) sleep_now [*2] |-> !bus_clock_out && !coproc_clock_out;
  endproperty
  a_sleep_low: assert property (p_sleep_low) else $error("clock high in sleep");

  property p_osc_gate;
    @(posedge sys_clk) disable iff (rst) osc_stop_req |=> !osc_ok ##1 !osc_ok;
  endproperty
  a_osc_gate: assert property (p_osc_gate) else $error("oscillator ungated early");

  property p_fifo;
    @(posedge sys_clk) disable iff (rst) !mode[icmc_pkg::MODE_FIFO] |=> serial_fifo_active == 2'h0;
  endproperty
  a_fifo: assert property (p_fifo) else $error("FIFO not forced off");

  property p_status_int;
    @(posedge sys_clk) disable iff (rst) !mode[icmc_pkg::MODE_IRQ] |=> parallel_status_int;
  endproperty
  a_status_int: assert property (p_status_int) else $error("status int not one");

  c_ptr_write: cover property (@(posedge sys_clk) disable iff (rst) ptr_wr ##[1:20] win_wr);
  c_sleep: cover property (@(posedge sys_clk) disable iff (rst) sleep_mode ##[1:20] !sleep_mode);
  c_osc_up: cover property (@(posedge sys_clk) disable iff (rst) $rose(osc_ok));
endmodule
`default_nettype wire

/* File: tb/icmc_host.sv */
// Host bus model: selects, strobes, address and write data
`default_nettype none
module icmc_host (
  input wire logic sys_clk,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  output logic parallel_port_select_n,
  output logic serial0_select_n,
  output logic serial1_select_n,
  output logic io_read_strobe_n,
  output logic io_write_strobe_n,
  output logic [2:0] host_addr,
  output logic [7:0] host_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus, nothing selected
  initial begin
    {parallel_port_select_n, serial0_select_n, serial1_select_n} = 3'h7;
    {io_read_strobe_n, io_write_strobe_n, host_addr, host_data_in} = 13'h1800;
  end
  // Six clocks low and high, since the synchroniser needs four
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    {parallel_port_select_n, host_addr, host_data_in} = {1'b0, a, d};
    io_write_strobe_n = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1 io_write_strobe_n = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 parallel_port_select_n = 1'b1;
    host_data_in = ~d; // Released bus shows no stale value
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk) #1;
    {parallel_port_select_n, io_read_strobe_n, host_addr} = {2'b00, a};
    while (host_data_oe !== 1'b1 && n < 20) begin
      @(posedge sys_clk) #1;
      n++;
    end
    d = (n < 20) ? host_data_out : 8'hxx; // Timeout reads unknown so the check fails
    io_read_strobe_n = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 parallel_port_select_n = 1'b1;
  endtask
  task automatic sl(input logic on);
    @(posedge sys_clk) #1;
    {parallel_port_select_n, serial0_select_n, serial1_select_n} = {3{~on}};
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench of the indexed clock and mode block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int OSC = 20;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic parallel_port_select_n, serial0_select_n, serial1_select_n, io_read_strobe_n;
  logic io_write_strobe_n, host_data_oe, mux_serial0_irq, mux_serial1_irq, mux_parallel_irq;
  logic [2:0] host_addr;
  logic [7:0] host_data_in, host_data_out;
  logic [1:0] serial0_clock_source, serial1_clock_source, serial_fifo_active;
  logic serial0_clock_gate, serial1_clock_gate, coproc_clock_out, keyboard_clock_out;
  logic bus_clock_out, oscillator_stop, sleep_mode, port_power_down, parallel_irq_style;
  logic parallel_bus_style, serial_fifo_allow, parallel_status_int, parallel_dir_effective;
  logic printer_selected_in = 1'b1, printer_busy_in = 1'b0, printer_paper_end_in = 1'b1;
  logic serial1_irq = 1'b0, serial0_irq = 1'b1, parallel_irq = 1'b0, parallel_dir_bit = 1'b1;
  logic [1:0] serial_fifo_enable = 2'b10;
  logic [3:0] serial0_irq_route, serial1_irq_route, parallel_irq_route;
  wire logic [2:0] mux_bits = {mux_serial1_irq, mux_serial0_irq, mux_parallel_irq};
  wire logic [7:0] mode_bits = {port_power_down, parallel_irq_style, parallel_bus_style,
    serial_fifo_allow, serial_fifo_active, parallel_status_int, parallel_dir_effective};
  int mismatches = 0;
  int checks_done = 0;
  icmc_top #(.OSC_START_CYCLES(OSC)) i_icmc_top (.sys_clk, .rst, .parallel_port_select_n,
    .serial0_select_n, .serial1_select_n, .io_read_strobe_n, .io_write_strobe_n, .host_addr,
    .host_data_in, .host_data_out, .host_data_oe, .printer_selected_in, .printer_busy_in,
    .printer_paper_end_in, .serial0_irq, .serial1_irq, .parallel_irq, .serial_fifo_enable,
    .parallel_dir_bit, .mux_serial0_irq, .mux_serial1_irq, .mux_parallel_irq,
    .serial0_clock_source, .serial1_clock_source, .serial0_clock_gate, .serial1_clock_gate,
    .coproc_clock_out, .keyboard_clock_out, .bus_clock_out, .oscillator_stop, .sleep_mode,
    .port_power_down, .parallel_irq_style, .parallel_bus_style, .serial_fifo_allow,
    .serial_fifo_active, .parallel_status_int, .parallel_dir_effective,
    .serial0_irq_route, .serial1_irq_route, .parallel_irq_route);
  icmc_host i_icmc_host (.sys_clk, .host_data_out, .host_data_oe, .parallel_port_select_n,
    .serial0_select_n, .serial1_select_n, .io_read_strobe_n, .io_write_strobe_n, .host_addr,
    .host_data_in);
  always #10 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_ptr();
    logic [7:0] d, v;
    for (int c = 0; c < 4; c++) begin
      v = {c[1], c[1:0], ~c[1:0], 3'h5};
      i_icmc_host.wr(3'h3, v);
      i_icmc_host.wr(3'h0, 8'h00);
      i_icmc_host.rd(3'h3, d);
      chk("pointer", v, d);
      chk("src", {c[1:0], ~c[1:0]}, {serial1_clock_source, serial0_clock_source});
      chk("mux", c[1] ? 8'h05 : 8'h02, mux_bits);
    end
    for (int i = 0; i < 7; i++) begin
      i_icmc_host.wr(3'h3, 8'(i));
      i_icmc_host.rd(3'h7, d);
      chk("reset", 8'h00, d);
    end
    $display("pointer test done");
  endtask
  task automatic t_gate();
    logic [7:0] d;
    i_icmc_host.wr(3'h7, 8'hFF);
    i_icmc_host.wr(3'h3, 8'h01);
    i_icmc_host.wr(3'h7, 8'hCE);
    i_icmc_host.rd(3'h7, d);
    chk("gating", 8'hCE, d);
    chk("stop", 8'h07, {serial1_clock_gate, serial0_clock_gate, oscillator_stop});
    i_icmc_host.wr(3'h7, 8'h0C);
    repeat (OSC + 10) @(posedge sys_clk);
    repeat (20) begin
      @(posedge sys_clk) #1;
      chk("low", 8'h00, {serial1_clock_gate, keyboard_clock_out, bus_clock_out});
    end
    i_icmc_host.wr(3'h7, 8'h00);
    d = 8'h00;
    repeat (32) begin
      @(posedge sys_clk) #1;
      d = d + 8'(keyboard_clock_out) + 8'(bus_clock_out);
    end
    chk("running", 8'h20, d);
    $display("gating test done");
  endtask
  task automatic t_cc();
    logic [7:0] n;
    logic [7:0] hi [8] = '{8'h14, 8'h0C, 8'h0F, 8'h1E, 8'h14, 8'h14, 8'h00, 8'h3C};
    i_icmc_host.wr(3'h3, 8'h00);
    for (int c = 0; c < 8; c++) begin
      i_icmc_host.wr(3'h7, 8'(c));
      n = 8'h00;
      repeat (10) @(posedge sys_clk);
      repeat (60) begin
        @(posedge sys_clk) #1;
        n = n + 8'(coproc_clock_out);
      end
      chk("coproc", hi[c], n);
    end
    $display("coprocessor clock test done");
  endtask
  task automatic t_mode();
    logic [7:0] d, v;
    i_icmc_host.wr(3'h3, 8'h05);
    for (int i = 0; i < 3; i++) begin
      v = i[0] ? 8'h00 : 8'h0F;
      i_icmc_host.wr(3'h7, v);
      i_icmc_host.rd(3'h7, d);
      chk("mode", v & 8'h0F, d);
      chk("mode_out", {v[3:0], v[0], 1'b0, ~v[2], v[1]}, mode_bits);
    end
    $display("mode test done");
  endtask
  task automatic t_sleep();
    logic [7:0] d;
    i_icmc_host.sl(1'b1);
    repeat (8) @(posedge sys_clk);
    repeat (20) begin
      @(posedge sys_clk) #1;
      chk("sleep", 8'h18, {sleep_mode, oscillator_stop, coproc_clock_out,
        keyboard_clock_out, bus_clock_out});
    end
    i_icmc_host.sl(1'b0);
    repeat (8) @(posedge sys_clk) #1;
    chk("wake", 8'h00, sleep_mode);
    repeat (OSC) @(posedge sys_clk);
    i_icmc_host.rd(3'h7, d);
    chk("kept", 8'h0F, d);
    $display("sleep test done");
  endtask
  // Routing registers are only stored, so their outputs must echo the writes
  task automatic t_route();
    logic [7:0] d;
    for (int i = 2; i < 5; i++) begin
      i_icmc_host.wr(3'h3, 8'(i));
      i_icmc_host.wr(3'h7, 8'(3 * i + 1));
      i_icmc_host.rd(3'h7, d);
      chk("route", 8'(3 * i + 1), d);
    end
    chk("s_routes", 8'h7A, {serial0_irq_route, serial1_irq_route});
    chk("p_route", 8'h0D, {4'h0, parallel_irq_route});
    $display("routing test done");
  endtask
  // Main sequence after sixteen reset clocks
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 rst = 1'b0;
    t_ptr();
    t_gate();
    t_cc();
    t_mode();
    t_sleep();
    t_route();
    final_report();
  end
  // Watchdog well beyond the under two thousand clocks the tests need
  initial begin
    #400_000;
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
